// ---- include/dbgig_map.vh ----
`ifndef DBGIG_MAP_VH
`define DBGIG_MAP_VH
`define DBGIG_WIDTH 16
`define DBGIG_MASK_RESET 16'h0000
`define DBGIG_BIT_RTOS 15
`define DBGIG_BIT_DATALOG 14
`define DBGIG_BIT_LEVEL14 13
`define DBGIG_BIT_LEVEL1 0
`endif

// ---- verilog/dbgig_level.v ----
`timescale 1ns/1ps
// one interrupt level: pending latch and acceptance qualification
module dbgig_level (
  input wire clk,
  input wire reset,
  input wire request,
  input wire cpu_enable,
  input wire debug_enable,
  input wire halted_rt,
  input wire global_ok,
  input wire taken,
  output reg pending,
  output wire eligible
);

  // when halted only time-critical levels count; when running the debug mask is ignored
  assign eligible = pending & cpu_enable & (~halted_rt | debug_enable); // R1 R3 R4

  // a request arriving in the acceptance cycle wins over the clear
  always @(posedge clk) begin
    if (reset) begin
      pending <= 1'b0;
    end else if (request) begin
      pending <= 1'b1; // R12
    end else if (taken) begin
      pending <= 1'b0;
    end
  end

  wire unused_ok;
  assign unused_ok = global_ok;

endmodule // dbgig_level

// ---- verilog/dbgig_gate.v ----
`timescale 1ns/1ps
`include "dbgig_map.vh"
// Function
// R1 - debug mask used only when halted real-time
// R2 - set mask bits mark time-critical levels
// R3 - halted: service needs debug and cpu enable
// R4 - running: standard handling, debug mask ignored
// R5 - mask readable and writable, one enables
// R6 - software uses push to read, pop to write
// R7 - reset clears all sixteen mask bits
// R8 - bit 15 gates the rtos interrupt
// R9 - bit 14 gates the data logging interrupt
// R10 - bits 13..0 gate levels 14..1
// R11 - serviced or non-trap software interrupt clears enable
// R12 - unserviced requests stay pending until eligible
module dbgig_gate #(
  parameter WIDTH = `DBGIG_WIDTH
) (
  input wire MCLK,
  input wire RESET,
  input wire HALTED_RT,
  input wire GLOBAL_OK,
  input wire [WIDTH-1:0] INT_REQUEST,
  input wire POP_DEBUG_MASK,
  input wire [WIDTH-1:0] POP_DATA,
  input wire PUSH_DEBUG_MASK,
  input wire CPU_MASK_WRITE,
  input wire [WIDTH-1:0] CPU_MASK_DATA,
  input wire SOFT_INT,
  input wire SOFT_INT_TRAP,
  input wire [3:0] SOFT_INT_INDEX,
  output reg [WIDTH-1:0] DEBUG_INTERRUPT_MASK,
  output reg [WIDTH-1:0] CPU_INTERRUPT_MASK,
  output reg [WIDTH-1:0] PUSH_DATA,
  output reg PUSH_VALID,
  output reg [WIDTH-1:0] PENDING,
  output reg TAKE_VALID,
  output reg [3:0] TAKE_INDEX,
  output reg [WIDTH-1:0] TIME_CRITICAL
);

  ////////////////////////////////////////////////////////////////
  wire [WIDTH-1:0] pending_bits;
  wire [WIDTH-1:0] eligible;
  reg [WIDTH-1:0] taken_onehot;
  reg any_take;
  reg [3:0] take_idx;
  reg [WIDTH-1:0] soft_clear;
  integer i;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : lvl
      dbgig_level u_level (
        .clk(MCLK),
        .reset(RESET),
        .request(INT_REQUEST[g]),
        .cpu_enable(CPU_INTERRUPT_MASK[g]),
        .debug_enable(DEBUG_INTERRUPT_MASK[g]), // R2 R8 R9 R10
        .halted_rt(HALTED_RT),
        .global_ok(GLOBAL_OK),
        .taken(taken_onehot[g]),
        .pending(pending_bits[g]),
        .eligible(eligible[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // lowest index wins, matching level 1 as highest priority
  always @* begin
    taken_onehot = {WIDTH{1'b0}};
    any_take = 1'b0;
    take_idx = 4'h0;
    for (i = WIDTH - 1; i >= 0; i = i - 1) begin
      if (eligible[i] && GLOBAL_OK) begin
        any_take = 1'b1;
        take_idx = i[3:0];
      end
    end
    if (any_take) begin
      taken_onehot[take_idx] = 1'b1;
    end
  end

  always @* begin
    soft_clear = {WIDTH{1'b0}};
    if (SOFT_INT && !SOFT_INT_TRAP) begin
      soft_clear[SOFT_INT_INDEX] = 1'b1; // R11
    end
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge MCLK) begin
    if (RESET) begin
      DEBUG_INTERRUPT_MASK <= `DBGIG_MASK_RESET; // R7
      CPU_INTERRUPT_MASK <= `DBGIG_MASK_RESET;
      PUSH_DATA <= {WIDTH{1'b0}};
      PUSH_VALID <= 1'b0;
      PENDING <= {WIDTH{1'b0}};
      TAKE_VALID <= 1'b0;
      TAKE_INDEX <= 4'h0;
      TIME_CRITICAL <= {WIDTH{1'b0}};
    end else begin
      // pop writes the mask; one enables a level, zero disables it
      if (POP_DEBUG_MASK) begin
        DEBUG_INTERRUPT_MASK <= POP_DATA; // R5 R6
      end
      // acceptance clear applies after any same-cycle software write
      if (CPU_MASK_WRITE) begin
        CPU_INTERRUPT_MASK <= CPU_MASK_DATA & ~taken_onehot & ~soft_clear; // R11
      end else begin
        CPU_INTERRUPT_MASK <= CPU_INTERRUPT_MASK & ~taken_onehot & ~soft_clear; // R11
      end
      PUSH_VALID <= PUSH_DEBUG_MASK; // R6
      if (PUSH_DEBUG_MASK) begin
        PUSH_DATA <= DEBUG_INTERRUPT_MASK; // R5
      end
      PENDING <= pending_bits; // R12
      TAKE_VALID <= any_take;
      TAKE_INDEX <= take_idx;
      TIME_CRITICAL <= HALTED_RT ? DEBUG_INTERRUPT_MASK : {WIDTH{1'b0}}; // R1 R2
    end
  end

endmodule // dbgig_gate

// ---- testbench/dbgig_gate_properties.sv ----
`timescale 1ns/1ps
module dbgig_gate_properties(input wire MCLK,input wire RESET,input wire HALTED_RT,input wire POP_DEBUG_MASK,
input wire PUSH_DEBUG_MASK,input wire PUSH_VALID,input wire TAKE_VALID,input wire [3:0] TAKE_INDEX,
input wire [15:0] POP_DATA,DEBUG_INTERRUPT_MASK,CPU_INTERRUPT_MASK,PUSH_DATA);
default clocking @(posedge MCLK); endclocking
default disable iff (RESET);
sequence push_ans;
PUSH_VALID && PUSH_DATA == $past(DEBUG_INTERRUPT_MASK);
endsequence
AST_RST: assert property ($past(RESET) |-> DEBUG_INTERRUPT_MASK == 16'h0000) else $error("reset");
AST_POP: assert property (POP_DEBUG_MASK |=> DEBUG_INTERRUPT_MASK == $past(POP_DATA)) else $error("pop");
AST_KEEP: assert property (!$past(RESET) && !$past(POP_DEBUG_MASK) |-> $stable(DEBUG_INTERRUPT_MASK)) else $error("k");
AST_PUSH: assert property (PUSH_DEBUG_MASK && !POP_DEBUG_MASK |=> push_ans) else $error("push");
AST_NOPUSH: assert property (!PUSH_DEBUG_MASK |=> !PUSH_VALID) else $error("extra push");
AST_CLR: assert property (TAKE_VALID |-> !CPU_INTERRUPT_MASK[TAKE_INDEX]) else $error("clear");
AST_EN: assert property (TAKE_VALID |-> $past(CPU_INTERRUPT_MASK) >> TAKE_INDEX & 1) else $error("enable");
AST_HALT: assert property (TAKE_VALID && $past(HALTED_RT) |-> $past(DEBUG_INTERRUPT_MASK) >> TAKE_INDEX & 1)
else $error("halt");
endmodule // dbgig_gate_properties

// ---- testbench/dbgig_cpu.sv ----
`timescale 1ns/1ps
// accepts only between instructions; slow stands for a long stall
module dbgig_cpu(input wire MCLK,input wire slow,output reg GLOBAL_OK=0);
reg [1:0] n=0;
always @(posedge MCLK) begin
  n<=n+1;
  GLOBAL_OK<=!slow||n==0;
end
endmodule // dbgig_cpu

// ---- testbench/debug_interrupt_gate_tb.sv ----
`timescale 1ns/1ps
module debug_interrupt_gate_tb;
reg MCLK=0,RESET=1,HALTED_RT=0,POP_DEBUG_MASK=0,PUSH_DEBUG_MASK=0,CPU_MASK_WRITE=0,SOFT_INT=0,SOFT_INT_TRAP=0,slow=0;
reg [15:0] INT_REQUEST=0,POP_DATA=0,CPU_MASK_DATA=0;
reg [3:0] SOFT_INT_INDEX=0;
reg [31:0] r;
wire GLOBAL_OK,PUSH_VALID,TAKE_VALID;
wire [3:0] TAKE_INDEX;
wire [15:0] DEBUG_INTERRUPT_MASK,CPU_INTERRUPT_MASK,PUSH_DATA,PENDING,TIME_CRITICAL;
reg [16:0] q[$];
integer fail_count=0,checked=0,i;
always #2 MCLK=~MCLK;
dbgig_gate dbgig_gate_i(.*);
dbgig_cpu dbgig_cpu_i(.*);
function [31:0] lfsr(input [31:0] v);
  lfsr={v[30:0],v[31]^v[21]^v[1]^v[0]};
endfunction
task chk(input ok);
  checked=checked+1;
  if(!ok) begin
    fail_count=fail_count+1;
    $display("wrong value at %0t mismatch",$time);
  end
endtask
task tally_and_finish;
  $display("checks %0d errors %0d",checked,fail_count);
  if(fail_count==0&&checked>0) $display("Simulation passed");
  else $display("Simulation failed");
  $finish;
endtask
// k: 0 pop, 1 push, 2 cpu mask write, 3 soft int, 4 request
task op(input [2:0] k,input [15:0] v);
  @(posedge MCLK);
  {SOFT_INT,CPU_MASK_WRITE,PUSH_DEBUG_MASK,POP_DEBUG_MASK}<=4'h1<<k;
  INT_REQUEST<=(k==4)?v:16'h0;
  {POP_DATA,CPU_MASK_DATA,SOFT_INT_INDEX}<={v,v,v[3:0]};
  @(posedge MCLK);
  {SOFT_INT,CPU_MASK_WRITE,PUSH_DEBUG_MASK,POP_DEBUG_MASK}<=4'h0;
  INT_REQUEST<=16'h0;
endtask
// bounded wait for every noted result; a hang ends the run
task drain;
  for(i=0;i<20&&q.size()>0;i=i+1) @(posedge MCLK);
  if(q.size()>0) begin
    chk(0);
    tally_and_finish;
  end
endtask
////////////////////////////////////////////////////////////////
always @(negedge MCLK) if(PUSH_VALID===1'b1||TAKE_VALID===1'b1) begin
  chk(q.size()>0&&q[0]===(PUSH_VALID?{1'b1,PUSH_DATA}:{13'h0,TAKE_INDEX}));
  if(q.size()>0) q.delete(0);
end
initial begin
  repeat(3) @(posedge MCLK);
  RESET<=0;
  q.push_back(17'h10000);
  op(1,0);
  r=lfsr(32'h539770b7);
  op(0,r[15:0]);
  q.push_back({1'b1,r[15:0]});
  op(1,0);
  op(0,16'h0008);
  op(2,16'hffff);
  @(posedge MCLK) HALTED_RT<=1;
  q.push_back(17'h3);
  op(4,16'h0028);
  drain;
  repeat(3) @(posedge MCLK);
  chk(PENDING===16'h0020&&TIME_CRITICAL===16'h0008);
  q.push_back(17'h5);
  HALTED_RT<=0;
  slow<=1;
  drain;
  repeat(3) @(posedge MCLK);
  chk(TIME_CRITICAL===16'h0000&&CPU_INTERRUPT_MASK===16'hffd7);
  op(3,16'h0001);
  @(negedge MCLK) chk(CPU_INTERRUPT_MASK===16'hffd5);
  // a trap-kind software interrupt must leave the enable bit alone
  @(posedge MCLK) SOFT_INT_TRAP<=1;
  op(3,16'h0004);
  @(negedge MCLK) chk(CPU_INTERRUPT_MASK===16'hffd5);
  tally_and_finish;
end
endmodule // debug_interrupt_gate_tb
bind dbgig_gate dbgig_gate_properties dbgig_gate_properties_i(.*);
